/* File: logic/operational_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module operational_regs
    import opreg_pkg::*;
#(
    parameter int IDLE_COUNT = opreg_pkg::IDLE_CYCLES,
    parameter int FIFO_DEPTH = 32,
    parameter int STACK_DEPTH = 8
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic WDT_RESET,
    input wire logic INSTR_DONE,
    input wire logic [3:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic [7:0] RAM_ADDR,
    output logic RAM_SEL,
    input wire logic [7:0] RAM_RDATA,
    input wire logic ALU_FLAGS_WE,
    input wire logic [2:0] ALU_FLAGS,
    input wire logic WDT_CLEAR_INSTR,
    input wire logic SLEEP_ENTER,
    input wire logic PORT_WAKE,
    input wire logic WDT_TIMEOUT,
    input wire logic PC_LOAD,
    input wire logic [12:0] PC_TARGET,
    input wire logic CALL,
    input wire logic RETURN,
    output logic [12:0] PC,
    input wire logic [7:0] PORT7_PINS,
    input wire logic [7:0] PORT7_DIR,
    input wire logic PS2_MODE,
    input wire logic DUAL_CLOCK,
    input wire logic NOISE_EVENT,
    input wire logic [7:0] INTERRUPT_ENABLE_WORD,
    output logic IRQ,
    input wire logic SETUP_OK,
    input wire logic ENGINE_FIFO_ACTIVE,
    input wire logic BUS_ACTIVITY,
    input wire logic EP2_RX_DONE,
    input wire logic [2:0] TX_DONE,
    input wire logic EP0_RX_DONE,
    input wire logic VENDOR_REQ,
    input wire logic SUSPEND_SEEN,
    input wire logic BUS_RESET_SEEN,
    input wire logic SUSPEND_LINE,
    output logic [7:0] HANDSHAKE,
    output logic EP2_ACCEPT,
    output logic EP0_ACCEPT,
    input wire logic ENGINE_WR,
    input wire logic [4:0] ENGINE_ADDR,
    input wire logic [7:0] ENGINE_WDATA,
    output logic [7:0] ENGINE_RDATA,
    output logic [7:0] PORT5_OUT,
    output logic [7:0] PORT6_OUT,
    output logic [7:0] PORT7_OUT,
    output logic [7:0] PORT8_OUT,
    output logic [7:0] PORT9_OUT
);
    localparam int CW = $clog2(IDLE_COUNT + 1);
    typedef struct packed {
        logic [7:0] tick;
        logic [12:0] pc;
        logic [7:0] status;
        logic [7:0] bank;
        logic [4:0][7:0] port;
        logic [7:0] noise;
        logic [7:0] hs;
        logic [4:0] fptr;
        logic [7:0] irqf;
        logic [7:0] p7_latch;
        logic [CW-1:0] idle_cnt;
        logic [3:0] p7_sync_a;
        logic [3:0] p7_sync_b;
        logic act_sync_a;
        logic act_sync_b;
        logic susp_sync_a;
        logic susp_sync_b;
        logic susp_prev;
        logic [7:0] rdata;
        logic [7:0] erdata;
    } regs_state_t;
    regs_state_t cur, next_cur;
    logic [FIFO_DEPTH-1:0][7:0] fifo_mem;
    logic [7:0] p7_now, pin_watch, pin_diff;
    logic wr_tick, wr_pcl, wr_status, wr_hs, wr_irq, wr_noise;
    stack_if #(.AW(13)) sk ();

    initial begin
        if (FIFO_DEPTH != 32 || STACK_DEPTH != 8 || IDLE_COUNT < 1) begin
            $error("operational_regs parameters out of range");
        end
    end

    return_stack #(.DEPTH(STACK_DEPTH), .AW(13)) u_stack (
        .MCLK(MCLK),
        .RST_N(RST_N),
        .sk(sk)
    );
    assign sk.push = CALL;
    assign sk.pop = RETURN;
    assign sk.push_addr = cur.pc + 13'h0001;

    // Watchdog reset clears tick, pc, page bits, timeout flag, noise, handshake bits other than busy and idle, irq flags and fifo pointer; power-down flag kept
    always_comb begin
        wr_tick = REG_WR && REG_ADDR == ADDR_TICK;
        wr_pcl = REG_WR && REG_ADDR == ADDR_PCL;
        wr_status = REG_WR && REG_ADDR == ADDR_STATUS;
        wr_hs = REG_WR && REG_ADDR == ADDR_USBHS;
        wr_irq = REG_WR && REG_ADDR == ADDR_IRQ;
        wr_noise = REG_WR && REG_ADDR == ADDR_NOISE;
        p7_now = {cur.p7_sync_b, 4'h0};
        pin_watch = PS2_MODE ? PORT7_PS2_MASK : PORT7_USB_MASK;
        pin_diff = (p7_now ^ cur.p7_latch) & PORT7_DIR & pin_watch;
    end

    always_comb begin
        next_cur = cur;
        // Pin synchronisers
        next_cur.p7_sync_a = PORT7_PINS[7:4];
        next_cur.p7_sync_b = cur.p7_sync_a;
        next_cur.act_sync_a = BUS_ACTIVITY;
        next_cur.act_sync_b = cur.act_sync_a;
        next_cur.susp_sync_a = SUSPEND_LINE;
        next_cur.susp_sync_b = cur.susp_sync_a;
        next_cur.susp_prev = cur.susp_sync_b;
        if (WDT_RESET) begin
            next_cur.tick = BYTE_ZERO;
            next_cur.pc = '0;
            next_cur.status[ST_TIMEOUT] = 1'b0;
            next_cur.status[7:ST_PAGE_LO] = '0;
            next_cur.noise = BYTE_ZERO;
            next_cur.hs = BYTE_ZERO;
            next_cur.irqf = BYTE_ZERO;
            next_cur.fptr = '0;
        end else begin
            if (wr_tick) begin
                next_cur.tick = REG_WDATA;
            end else if (INSTR_DONE) begin
                next_cur.tick = cur.tick + 8'h01;
            end
            // Program counter
            if (PC_LOAD || CALL) begin
                next_cur.pc = PC_TARGET;
            end else if (RETURN) begin
                next_cur.pc = sk.top_addr;
            end else if (wr_pcl) begin
                next_cur.pc = {cur.status[7:ST_PAGE_LO], 2'b00, REG_WDATA};
            end else if (INSTR_DONE) begin
                next_cur.pc = cur.pc + 13'h0001;
            end
            if (wr_status) begin
                next_cur.status[ST_ZERO:ST_CARRY] = REG_WDATA[ST_ZERO:ST_CARRY];
                if (REG_WDATA[7:ST_PAGE_LO] <= LAST_PAGE) begin
                    next_cur.status[7:ST_PAGE_LO] = REG_WDATA[7:ST_PAGE_LO];
                end
            end
            if (ALU_FLAGS_WE) begin
                next_cur.status[ST_ZERO:ST_CARRY] = ALU_FLAGS;
            end
            if (WDT_CLEAR_INSTR) begin
                next_cur.status[ST_PDOWN] = 1'b1;
                next_cur.status[ST_TIMEOUT] = 1'b1;
            end else if (WDT_TIMEOUT) begin
                next_cur.status[ST_TIMEOUT] = 1'b0;
            end else if (SLEEP_ENTER || PORT_WAKE) begin
                next_cur.status[ST_PDOWN] = 1'b0;
                next_cur.status[ST_TIMEOUT] = 1'b1;
            end
            if (REG_WR && REG_ADDR == ADDR_BANK) begin
                next_cur.bank = REG_WDATA;
            end
            if (REG_WR && REG_ADDR >= ADDR_PORT5 && REG_ADDR <= ADDR_PORT9) begin
                next_cur.port[REG_ADDR - ADDR_PORT5] = REG_WDATA;
            end
            if (REG_RD && REG_ADDR == ADDR_PORT7) begin
                next_cur.p7_latch = p7_now;
            end
            // Noise flag
            if (wr_noise) begin
                next_cur.noise = REG_WDATA & ~(8'h01 << NOISE_BIT);
                next_cur.noise[NOISE_BIT] = cur.noise[NOISE_BIT] & REG_WDATA[NOISE_BIT];
            end
            if (NOISE_EVENT) begin
                next_cur.noise[NOISE_BIT] = 1'b1;
            end
            // Handshake word: firmware may set stall, tx requests and ep0 rx
            if (wr_hs) begin
                next_cur.hs[HS_STALL] = REG_WDATA[HS_STALL];
                next_cur.hs[HS_EP2_RX] = cur.hs[HS_EP2_RX] & REG_WDATA[HS_EP2_RX];
                next_cur.hs[HS_EP0_RX] = REG_WDATA[HS_EP0_RX];
                next_cur.hs[HS_EP0_TX:HS_EP2_TX] =
                    cur.hs[HS_EP0_TX:HS_EP2_TX] | REG_WDATA[HS_EP0_TX:HS_EP2_TX];
            end
            if (SETUP_OK) begin
                next_cur.hs[HS_STALL] = 1'b0;
            end
            // TX_DONE bit0 = ep2, bit2 = ep0; only hardware clears
            next_cur.hs[HS_EP0_TX:HS_EP2_TX] &= ~TX_DONE;
            if (EP2_RX_DONE && !cur.hs[HS_EP2_RX]) begin
                next_cur.hs[HS_EP2_RX] = 1'b1;
            end
            if (EP0_RX_DONE && !cur.hs[HS_EP0_RX]) begin
                next_cur.hs[HS_EP0_RX] = 1'b1;
            end
            if (REG_WR && REG_ADDR == ADDR_FIFOPTR) begin
                next_cur.fptr = REG_WDATA[4:0];
            end
            // Interrupt flags: firmware write of zero clears, hardware set wins
            if (wr_irq) begin
                next_cur.irqf = cur.irqf & REG_WDATA & IF_USED;
            end
            if (INSTR_DONE && !wr_tick && cur.tick == BYTE_MAX) begin
                next_cur.irqf[IF_TICK] = 1'b1;
            end
            if (VENDOR_REQ) begin
                next_cur.irqf[IF_EP0] = 1'b1;
            end
            if (SUSPEND_SEEN) begin
                next_cur.irqf[IF_SUSP] = 1'b1;
            end
            if (BUS_RESET_SEEN) begin
                next_cur.irqf[IF_BRST] = 1'b1;
            end
            if (|pin_diff) begin
                next_cur.irqf[IF_PIN] = 1'b1;
            end
            if (DUAL_CLOCK && cur.susp_prev && !cur.susp_sync_b) begin
                next_cur.irqf[IF_RESUME] = 1'b1;
            end
        end
        // Idle timer on synchronised activity
        if (cur.act_sync_b) begin
            next_cur.idle_cnt = '0;
            next_cur.hs[HS_IDLE] = 1'b0;
        end else if (cur.idle_cnt >= CW'(IDLE_COUNT)) begin
            next_cur.hs[HS_IDLE] = 1'b1;
        end else begin
            next_cur.idle_cnt = cur.idle_cnt + 1'b1;
        end
        next_cur.hs[HS_BUSY] = ENGINE_FIFO_ACTIVE;
        // Read mux, registered
        unique case (REG_ADDR)
            ADDR_INDIRECT: next_cur.rdata = RAM_RDATA;
            ADDR_TICK: next_cur.rdata = cur.tick;
            ADDR_PCL: next_cur.rdata = cur.pc[7:0];
            ADDR_STATUS: next_cur.rdata = cur.status;
            ADDR_BANK: next_cur.rdata = cur.bank;
            ADDR_PORT5, ADDR_PORT6, ADDR_PORT8, ADDR_PORT9:
                next_cur.rdata = cur.port[REG_ADDR - ADDR_PORT5];
            ADDR_PORT7: next_cur.rdata = {p7_now[7:4], cur.port[2][3:0]};
            ADDR_NOISE: next_cur.rdata = cur.noise;
            ADDR_USBHS: next_cur.rdata = cur.hs;
            ADDR_FIFOPTR: next_cur.rdata = {3'h0, cur.fptr};
            ADDR_FIFODATA: next_cur.rdata = fifo_mem[cur.fptr];
            ADDR_IRQ: next_cur.rdata = cur.irqf;
            default: next_cur.rdata = BYTE_ZERO;
        endcase
        next_cur.erdata = fifo_mem[ENGINE_ADDR];
    end

    // FIFO window: a firmware write wins a same-cycle clash with the engine
    always_ff @(posedge MCLK) begin
        if (REG_WR && REG_ADDR == ADDR_FIFODATA) begin
            fifo_mem[cur.fptr] <= REG_WDATA;
        end else if (ENGINE_WR) begin
            fifo_mem[ENGINE_ADDR] <= ENGINE_WDATA;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cur <= '0;
            cur.status <= STATUS_POR;
        end else begin
            cur <= next_cur;
        end
    end

    assign RAM_ADDR = cur.bank[5:0] <= COMMON_TOP ? {2'b00, cur.bank[5:0]} : cur.bank;
    assign RAM_SEL = (REG_WR || REG_RD) && REG_ADDR == ADDR_INDIRECT;
    assign REG_RDATA = cur.rdata;
    assign ENGINE_RDATA = cur.erdata;
    assign PC = cur.pc;
    assign HANDSHAKE = cur.hs;
    assign EP2_ACCEPT = !cur.hs[HS_EP2_RX];
    assign EP0_ACCEPT = !cur.hs[HS_EP0_RX];
    assign IRQ = |(cur.irqf & INTERRUPT_ENABLE_WORD & IF_USED);
    assign PORT5_OUT = cur.port[0];
    assign PORT6_OUT = cur.port[1];
    assign PORT7_OUT = cur.port[2];
    assign PORT8_OUT = cur.port[3];
    assign PORT9_OUT = cur.port[4];

    a_tick_wrap_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
        (INSTR_DONE && !wr_tick && !WDT_RESET && cur.tick == 8'hff) |=> cur.irqf[0])
        else $error("tick wrap did not set flag");
    a_tick_advance: assert property (@(posedge MCLK) disable iff (!RST_N)
        (INSTR_DONE && !REG_WR && !WDT_RESET) |=> cur.tick == $past(cur.tick) + 8'h01)
        else $error("tick did not advance");
    a_wdt_clears_pc: assert property (@(posedge MCLK) disable iff (!RST_N)
        WDT_RESET |=> (PC == 13'h0000 && cur.tick == 8'h00))
        else $error("watchdog reset left pc or tick");
    a_pdown_keep: assert property (@(posedge MCLK) disable iff (!RST_N)
        WDT_RESET |=> $stable(cur.status[3]))
        else $error("power-down flag changed on watchdog");
    a_stall_setup: assert property (@(posedge MCLK) disable iff (!RST_N)
        (SETUP_OK && !WDT_RESET) |=> !HANDSHAKE[0])
        else $error("stall not cleared by setup");
    a_busy_follow: assert property (@(posedge MCLK) disable iff (!RST_N)
        ENGINE_FIFO_ACTIVE |=> HANDSHAKE[1])
        else $error("busy bit not raised");
    a_ep2_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
        (HANDSHAKE[3] && !wr_hs && !WDT_RESET) |=> HANDSHAKE[3] && !EP2_ACCEPT)
        else $error("ep2 receive bit lost");
    a_irq_gate: assert property (@(posedge MCLK) disable iff (!RST_N)
        (INTERRUPT_ENABLE_WORD == 8'h00) |-> !IRQ)
        else $error("interrupt raised while disabled");
    a_set_wins: assert property (@(posedge MCLK) disable iff (!RST_N)
        (VENDOR_REQ && wr_irq && !WDT_RESET) |=> cur.irqf[1])
        else $error("clear beat hardware set");
endmodule // operational_regs
`default_nettype wire

/* File: logic/opreg_pkg.sv */
`default_nettype none
package opreg_pkg;
    localparam logic [3:0] ADDR_INDIRECT = 4'h0;
    localparam logic [3:0] ADDR_TICK = 4'h1;
    localparam logic [3:0] ADDR_PCL = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_BANK = 4'h4;
    localparam logic [3:0] ADDR_PORT5 = 4'h5;
    localparam logic [3:0] ADDR_PORT6 = 4'h6;
    localparam logic [3:0] ADDR_PORT7 = 4'h7;
    localparam logic [3:0] ADDR_PORT8 = 4'h8;
    localparam logic [3:0] ADDR_PORT9 = 4'h9;
    localparam logic [3:0] ADDR_NOISE = 4'ha;
    localparam logic [3:0] ADDR_USBHS = 4'hc;
    localparam logic [3:0] ADDR_FIFOPTR = 4'hd;
    localparam logic [3:0] ADDR_FIFODATA = 4'he;
    localparam logic [3:0] ADDR_IRQ = 4'hf;
    // Status word bit positions
    localparam int ST_CARRY = 0;
    localparam int ST_NIBBLE = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_PDOWN = 3;
    localparam int ST_TIMEOUT = 4;
    localparam int ST_PAGE_LO = 5;
    // Handshake word bit positions
    localparam int HS_STALL = 0;
    localparam int HS_BUSY = 1;
    localparam int HS_IDLE = 2;
    localparam int HS_EP2_RX = 3;
    localparam int HS_EP2_TX = 4;
    localparam int HS_EP1_TX = 5;
    localparam int HS_EP0_TX = 6;
    localparam int HS_EP0_RX = 7;
    // Interrupt flag bit positions
    localparam int IF_TICK = 0;
    localparam int IF_EP0 = 1;
    localparam int IF_SUSP = 2;
    localparam int IF_BRST = 3;
    localparam int IF_PIN = 4;
    localparam int IF_RESUME = 7;
    localparam int NOISE_BIT = 4;
    localparam logic [7:0] IF_USED = 8'h9f;
    localparam logic [7:0] STATUS_POR = 8'h18;
    localparam logic [7:0] PORT7_PS2_MASK = 8'hf0;
    localparam logic [7:0] PORT7_USB_MASK = 8'hc0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [5:0] COMMON_TOP = 6'h1f;
    localparam logic [2:0] LAST_PAGE = 3'h5;
    localparam int IDLE_TIME_US = 3000;
    localparam int CLOCK_MHZ = 20;
    localparam int IDLE_CYCLES = IDLE_TIME_US * CLOCK_MHZ;
endpackage
`default_nettype wire

/* File: logic/return_stack.sv */
`timescale 1ns/1ns
`default_nettype none
module return_stack #(
    parameter int DEPTH = 8,
    parameter int AW = 13
) (
    input wire logic MCLK,
    input wire logic RST_N,
    stack_if.store sk
);
    typedef struct packed {
        logic [DEPTH-1:0][AW-1:0] slot;
        logic [$clog2(DEPTH)-1:0] sp;
    } stack_state_t;
    stack_state_t cur, next_cur;
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("return_stack depth must be a power of two");
        end
    end
    // Circular: a ninth push overwrites the oldest entry, as in the core
    always_comb begin
        next_cur = cur;
        if (sk.push) begin
            next_cur.slot[cur.sp] = sk.push_addr;
            next_cur.sp = cur.sp + 1'b1;
        end else if (sk.pop) begin
            next_cur.sp = cur.sp - 1'b1;
        end
    end
    assign sk.top_addr = cur.slot[cur.sp - 1'b1];
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end
endmodule // return_stack
`default_nettype wire

/* File: logic/stack_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface stack_if #(parameter int AW = 13);
    logic push;
    logic pop;
    logic [AW-1:0] push_addr;
    logic [AW-1:0] top_addr;
    modport user (output push, output pop, output push_addr, input top_addr);
    modport store (input push, input pop, input push_addr, output top_addr);
endinterface
`default_nettype wire

/* File: verif/tb_operational_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_operational_regs;
    import opreg_pkg::*;
    localparam int IDLE_SIM = 20;
    localparam logic [3:0] RST_ADDR [9] = '{ADDR_TICK, ADDR_PCL, ADDR_STATUS, ADDR_PORT5,
        ADDR_PORT6, ADDR_PORT8, ADDR_NOISE, ADDR_FIFOPTR, ADDR_IRQ};
    localparam logic [7:0] RST_EXP [9] = '{8'h00, 8'h00, STATUS_POR, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00};
    logic mclk = 0, rst_n = 0, wdt_reset = 0, instr_done = 0, reg_wr = 0, reg_rd = 0;
    logic alu_flags_we = 0, wdt_clear_instr = 0, sleep_enter = 0, port_wake = 0;
    logic wdt_timeout = 0, pc_load = 0, call = 0, ret = 0, ps2_mode = 0, dual_clock = 0;
    logic noise_event = 0, setup_ok = 0, engine_fifo_active = 0, bus_activity = 1;
    logic ep2_rx_done = 0, ep0_rx_done = 0, vendor_req = 0, suspend_seen = 0;
    logic bus_reset_seen = 0, suspend_line = 0, engine_wr = 0;
    logic irq, ep2_accept, ep0_accept, ram_sel;
    logic [3:0] reg_addr = 4'h0;
    logic [2:0] alu_flags = 3'h0, tx_done = 3'h0;
    logic [4:0] engine_addr = 5'h00;
    logic [12:0] pc_target = 13'h0000, pc;
    logic [7:0] reg_wdata = 8'h00, ram_rdata = 8'h00, port7_pins = 8'h00, port7_dir = 8'hff;
    logic [7:0] ie_word = 8'h00, engine_wdata = 8'h00;
    logic [7:0] reg_rdata, ram_addr, handshake, engine_rdata;
    logic [7:0] port_out [5];
    int errors = 0, n_checks = 0;
    operational_regs #(.IDLE_COUNT(IDLE_SIM)) operational_regs_inst (
        .MCLK(mclk), .RST_N(rst_n), .WDT_RESET(wdt_reset), .INSTR_DONE(instr_done),
        .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .RAM_ADDR(ram_addr), .RAM_SEL(ram_sel), .RAM_RDATA(ram_rdata),
        .ALU_FLAGS_WE(alu_flags_we), .ALU_FLAGS(alu_flags), .WDT_CLEAR_INSTR(wdt_clear_instr),
        .SLEEP_ENTER(sleep_enter), .PORT_WAKE(port_wake), .WDT_TIMEOUT(wdt_timeout),
        .PC_LOAD(pc_load), .PC_TARGET(pc_target), .CALL(call), .RETURN(ret), .PC(pc),
        .PORT7_PINS(port7_pins), .PORT7_DIR(port7_dir), .PS2_MODE(ps2_mode),
        .DUAL_CLOCK(dual_clock), .NOISE_EVENT(noise_event), .INTERRUPT_ENABLE_WORD(ie_word),
        .IRQ(irq), .SETUP_OK(setup_ok), .ENGINE_FIFO_ACTIVE(engine_fifo_active),
        .BUS_ACTIVITY(bus_activity), .EP2_RX_DONE(ep2_rx_done), .TX_DONE(tx_done),
        .EP0_RX_DONE(ep0_rx_done), .VENDOR_REQ(vendor_req), .SUSPEND_SEEN(suspend_seen),
        .BUS_RESET_SEEN(bus_reset_seen), .SUSPEND_LINE(suspend_line), .HANDSHAKE(handshake),
        .EP2_ACCEPT(ep2_accept), .EP0_ACCEPT(ep0_accept), .ENGINE_WR(engine_wr),
        .ENGINE_ADDR(engine_addr), .ENGINE_WDATA(engine_wdata), .ENGINE_RDATA(engine_rdata),
        .PORT5_OUT(port_out[0]), .PORT6_OUT(port_out[1]), .PORT7_OUT(port_out[2]),
        .PORT8_OUT(port_out[3]), .PORT9_OUT(port_out[4])
    );
    always #25 mclk = ~mclk;
    // Inputs move 2 ns after the edge so the design never races the bench
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // The idle cycle after each access keeps two strobes from meeting in one time step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
        step(1);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        step(1);
        reg_rd = 1'b0;
        step(1);
        chk({8'h00, reg_rdata & m}, {8'h00, e & m}, $sformatf("register %h", a));
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end
    initial begin
        step(5);
        rst_n = 1'b1;
        step(1);
        foreach (RST_ADDR[i]) rd(RST_ADDR[i], 8'hff, RST_EXP[i]);
        rd(ADDR_USBHS, 8'hff, 8'h00);
        chk({3'h0, pc}, 16'h0000, "pc after reset");
        $display("test reset values done");
        wr(ADDR_TICK, BYTE_MAX);
        instr_done = 1'b1;
        step(1);
        instr_done = 1'b0;
        step(1);
        rd(ADDR_TICK, 8'hff, 8'h00);
        rd(ADDR_IRQ, 8'h01, 8'h01);
        chk({15'h0, irq}, 16'h0000, "masked tick irq");
        ie_word = 8'h01;
        step(1);
        chk({15'h0, irq}, 16'h0001, "enabled tick irq");
        wr(ADDR_IRQ, 8'h00);
        ie_word = 8'h00;
        $display("test tick done");
        wr(ADDR_STATUS, 8'ha0);
        wr(ADDR_STATUS, 8'hc0);
        rd(ADDR_STATUS, 8'he0, 8'ha0);
        alu_flags = 3'b101;
        alu_flags_we = 1'b1;
        step(1);
        alu_flags_we = 1'b0;
        step(1);
        rd(ADDR_STATUS, 8'h07, 8'h05);
        sleep_enter = 1'b1;
        step(1);
        sleep_enter = 1'b0;
        port_wake = 1'b1;
        step(1);
        port_wake = 1'b0;
        step(1);
        rd(ADDR_STATUS, 8'h18, 8'h10);
        wdt_clear_instr = 1'b1;
        step(1);
        wdt_clear_instr = 1'b0;
        wdt_timeout = 1'b1;
        step(1);
        wdt_timeout = 1'b0;
        noise_event = 1'b1;
        step(1);
        noise_event = 1'b0;
        step(1);
        rd(ADDR_STATUS, 8'h18, 8'h08);
        rd(ADDR_NOISE, 8'h10, 8'h10);
        wr(ADDR_TICK, 8'h42);
        wdt_reset = 1'b1;
        step(1);
        wdt_reset = 1'b0;
        step(1);
        rd(ADDR_STATUS, 8'hf8, 8'h08);
        rd(ADDR_NOISE, 8'h10, 8'h00);
        rd(ADDR_TICK, 8'hff, 8'h00);
        $display("test status done");
        pc_target = 13'h0123;
        pc_load = 1'b1;
        step(1);
        pc_load = 1'b0;
        pc_target = 13'h0400;
        call = 1'b1;
        step(1);
        call = 1'b0;
        step(1);
        chk({3'h0, pc}, 16'h0400, "pc after call");
        ret = 1'b1;
        step(1);
        ret = 1'b0;
        step(1);
        chk({3'h0, pc}, 16'h0124, "pc after return");
        rd(ADDR_PCL, 8'hff, 8'h24);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_PORT5 + 4'(i), 8'h50 + 8'(i));
            chk({8'h00, port_out[i]}, {8'h00, 8'h50 + 8'(i)}, "port output");
        end
        rd(ADDR_PORT8, 8'hff, 8'h53);
        wr(ADDR_BANK, 8'h8c);
        chk({8'h00, ram_addr}, 16'h000c, "common space address");
        wr(ADDR_BANK, 8'hbc);
        chk({8'h00, ram_addr}, 16'h00bc, "banked address");
        ram_rdata = 8'h3c;
        reg_addr = ADDR_INDIRECT;
        reg_rd = 1'b1;
        step(1);
        chk({15'h0, ram_sel}, 16'h0001, "indirect select");
        reg_rd = 1'b0;
        step(1);
        chk({15'h0, ram_sel}, 16'h0000, "indirect select idle");
        rd(ADDR_INDIRECT, 8'hff, 8'h3c);
        wr(ADDR_FIFOPTR, BYTE_MAX);
        rd(ADDR_FIFOPTR, 8'hff, 8'h1f);
        wr(ADDR_FIFOPTR, 8'h03);
        wr(ADDR_FIFODATA, 8'h5a);
        engine_addr = 5'h03;
        step(1);
        chk({8'h00, engine_rdata}, 16'h005a, "engine sees firmware byte");
        engine_addr = 5'h04;
        engine_wdata = 8'hc3;
        engine_wr = 1'b1;
        step(1);
        engine_wr = 1'b0;
        wr(ADDR_FIFOPTR, 8'h04);
        rd(ADDR_FIFODATA, 8'hff, 8'hc3);
        $display("test pc bank fifo done");
        wr(ADDR_USBHS, 8'h71);
        wr(ADDR_USBHS, 8'h01);
        rd(ADDR_USBHS, 8'hf9, 8'h71);
        setup_ok = 1'b1;
        step(1);
        setup_ok = 1'b0;
        tx_done = 3'b111;
        step(1);
        tx_done = 3'b000;
        ep2_rx_done = 1'b1;
        ep0_rx_done = 1'b1;
        engine_fifo_active = 1'b1;
        step(1);
        ep2_rx_done = 1'b0;
        ep0_rx_done = 1'b0;
        rd(ADDR_USBHS, 8'hff, 8'h8a);
        chk({14'h0, ep2_accept, ep0_accept}, 16'h0000, "engine locked out");
        engine_fifo_active = 1'b0;
        wr(ADDR_USBHS, 8'h00);
        chk({14'h0, ep2_accept, ep0_accept}, 16'h0003, "accepts again");
        bus_activity = 1'b0;
        step(10);
        chk({15'h0, handshake[HS_IDLE]}, 16'h0000, "idle too early");
        step(IDLE_SIM);
        rd(ADDR_USBHS, 8'h04, 8'h04);
        bus_activity = 1'b1;
        step(4);
        rd(ADDR_USBHS, 8'h04, 8'h00);
        $display("test handshake done");
        ps2_mode = 1'b1;
        dual_clock = 1'b1;
        suspend_line = 1'b1;
        rd(ADDR_PORT7, 8'hf0, 8'h00);
        port7_pins = 8'h10;
        suspend_seen = 1'b1;
        bus_reset_seen = 1'b1;
        step(1);
        suspend_seen = 1'b0;
        bus_reset_seen = 1'b0;
        suspend_line = 1'b0;
        step(4);
        rd(ADDR_IRQ, IF_USED, 8'h9c);
        rd(ADDR_PORT7, 8'hf0, 8'h10);
        reg_addr = ADDR_IRQ;
        reg_wdata = 8'h00;
        reg_wr = 1'b1;
        vendor_req = 1'b1;
        step(1);
        reg_wr = 1'b0;
        vendor_req = 1'b0;
        step(1);
        rd(ADDR_IRQ, IF_USED, 8'h02);
        $display("test irq collision done");
        conclude();
    end
endmodule // tb_operational_regs
`default_nettype wire
